//--- core/csu_pkg.sv
// Package for the compare-and-skip execution unit.
// Assumes a core that runs four quarter-cycles per instruction cycle.
package csu_pkg;

  // Opcode upper seven bits (bit 8 is the bank selector)
  localparam logic [6:0] CSU_OP_GREATER  = 7'h32;
  localparam logic [6:0] CSU_OP_LESS     = 7'h30;
  // Field positions within the 16-bit program word
  localparam int         CSU_OP_MSB      = 15;
  localparam int         CSU_OP_LSB      = 9;
  localparam int         CSU_BANK_BIT    = 8;
  localparam int         CSU_ADDR_MSB    = 7;
  // Highest address field handled by indexed literal offset mode
  localparam logic [7:0] CSU_INDEX_LIMIT = 8'h5F;
  // Quick-access bank: low half maps to bank 0, high half to bank 15
  localparam logic [7:0] CSU_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] CSU_ACCESS_HIGH  = 4'hF;
  localparam logic [3:0] CSU_ACCESS_LOW   = 4'h0;
  // Time figures
  localparam int         CSU_CLK_NS      = 100;
  localparam int         CSU_QUARTERS    = 4;
  // Reset values
  localparam logic [1:0] CSU_RST_SKIPS   = 2'h0;

  // Quarter-cycle sequencer, one-hot
  typedef enum logic [3:0] {
    CSU_Q1 = 4'b0001,
    CSU_Q2 = 4'b0010,
    CSU_Q3 = 4'b0100,
    CSU_Q4 = 4'b1000
  } csu_quarter_t;

  // Data memory request towards the core
  typedef struct packed {
    logic        rd;        // Read strobe in quarter two
    logic [11:0] addr;      // Resolved 12-bit address
    logic        indexed;   // Address is index-relative
  } csu_mem_req_t;

endpackage : csu_pkg

//--- core/csu_addr_resolve.sv
// Operand address resolver for the compare-and-skip unit.
// Assumes the bank select register and index base come from the core.
`timescale 1ns/1ps
`default_nettype none
module csu_addr_resolve
  import csu_pkg::*;
(
  // Instruction fields
  input  wire logic [7:0]  i_addr_field,
  input  wire logic        i_bank_sel,
  input  wire logic        i_is_greater,
  // Core state
  input  wire logic [3:0]  i_bank_select_register,
  input  wire logic        i_ext_set_en,
  input  wire logic [11:0] i_index_base,
  // Result
  output logic [11:0]      o_addr,
  output logic             o_indexed
);

  // Pure combinational address mapping
  always_comb begin
    o_indexed = 1'b0;
    if (i_bank_sel) begin
      // Banked general_purpose_bank access (see RULE9)
      o_addr = {i_bank_select_register, i_addr_field};
    end else if (i_ext_set_en && i_is_greater &&
                 (i_addr_field <= CSU_INDEX_LIMIT)) begin
      // Index base plus literal offset (see RULE10)
      o_addr    = i_index_base + {4'h0, i_addr_field};
      o_indexed = 1'b1;
    end else if (i_addr_field >= CSU_ACCESS_SPLIT) begin
      // Quick-access bank, upper half (see RULE8)
      o_addr = {CSU_ACCESS_HIGH, i_addr_field};
    end else begin
      // Quick-access bank, lower half (see RULE8)
      o_addr = {CSU_ACCESS_LOW, i_addr_field};
    end
  end

endmodule : csu_addr_resolve
`default_nettype wire

//--- core/csu_compare_skip.sv
// Compare-and-skip execution unit: decode, operand fetch, compare, skip.
// Assumes the core presents a new word at each instruction-cycle Q1 and
// returns read data by the end of Q2.
// Overview of operation
// RULE1: Decode 0110010a greater, 0110000a less opcodes
// RULE2: Greater skip when byte exceeds working register
// RULE3: Less skip when byte below working register
// RULE4: Unsigned subtraction; no result, no flags
// RULE5: One word; one cycle, two if skipped
// RULE6: Skip over two-word successor takes three
// RULE7: Every extra skip cycle does nothing
// RULE8: Bank bit zero selects quick-access bank
// RULE9: Bank bit one uses bank select register
// RULE10: Extended set, a=0, f<=95: indexed greater
// RULE11: Q1 decode, Q2 read, Q3 compare, Q4 idle
`timescale 1ns/1ps
`default_nettype none
module csu_compare_skip
  import csu_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Instruction stream
  input  wire logic [15:0] i_instr,
  input  wire logic        i_next_two_word,
  // Core state
  input  wire logic [7:0]  i_working_register,
  input  wire logic [3:0]  i_bank_select_register,
  input  wire logic        i_ext_set_en,
  input  wire logic [11:0] i_index_base,
  // Data memory
  input  wire logic [7:0]  i_mem_rdata,
  output logic             o_mem_rd,
  output logic [11:0]      o_mem_addr,
  output logic             o_mem_indexed,
  // Status
  output logic [3:0]       o_quarter,
  output logic             o_busy,
  output logic             o_skip_taken,
  output logic             o_nop_cycle
);

  // Whole unit state in one struct
  typedef struct packed {
    csu_quarter_t q;        // Current quarter
    logic         active;   // Compare instruction in progress
    logic         greater;  // Greater form decoded
    logic [7:0]   working_register;     // Working register snapshot
    csu_mem_req_t mem;      // Memory request
    logic [7:0]   opnd;     // Operand read in Q2
    logic [1:0]   skips;    // Extra no-op cycles remaining
    logic         nop;      // Current cycle is a no-op cycle
    logic         taken;    // Pulse at end of a taken compare
  } csu_state_t;

  csu_state_t st;           // Registered state
  csu_state_t next_st;      // Next state

  logic       dec_greater;  // Word is the greater form
  logic       dec_less;     // Word is the less form
  logic [11:0] res_addr;    // Resolved address
  logic        res_indexed; // Resolved as indexed

  // Opcode match on the upper seven bits
  function automatic logic op_is(input logic [15:0] w,
                                 input logic [6:0]  op);
    op_is = (w[CSU_OP_MSB:CSU_OP_LSB] == op);
  endfunction : op_is

  // Unsigned subtraction f - w; borrow clear means f >= w
  function automatic logic [8:0] sub_u(input logic [7:0] f,
                                       input logic [7:0] w);
    sub_u = {1'b0, f} - {1'b0, w};
  endfunction : sub_u

  assign dec_greater = op_is(i_instr, CSU_OP_GREATER); // see RULE1
  assign dec_less    = op_is(i_instr, CSU_OP_LESS);    // see RULE1

  // Address resolution, kept separate so it can be shared later
  csu_addr_resolve u_resolve (
    .i_addr_field           (i_instr[CSU_ADDR_MSB:0]),
    .i_bank_sel             (i_instr[CSU_BANK_BIT]),
    .i_is_greater           (dec_greater),
    .i_bank_select_register (i_bank_select_register),
    .i_ext_set_en           (i_ext_set_en),
    .i_index_base           (i_index_base),
    .o_addr                 (res_addr),
    .o_indexed              (res_indexed)
  );

  // Next-state logic
  always_comb begin
    logic [8:0] diff;
    logic       hit;
    diff    = 9'h000;
    hit     = 1'b0;
    next_st = st;
    next_st.taken  = 1'b0;
    next_st.mem.rd = 1'b0;
    case (st.q)
      CSU_Q1: begin
        next_st.q = CSU_Q2;
        // Decode only outside skip cycles (see RULE11)
        // A no-op cycle refuses any word, even a compare (see RULE7)
        if (st.skips == CSU_RST_SKIPS && !st.nop &&
            (dec_greater || dec_less)) begin
          next_st.active      = 1'b1;
          next_st.greater     = dec_greater;
          next_st.working_register        = i_working_register;
          next_st.mem.addr    = res_addr;      // see RULE8
          next_st.mem.indexed = res_indexed;   // see RULE10
          next_st.mem.rd      = 1'b1;          // Read in Q2, see RULE11
        end else begin
          next_st.active = 1'b0;
        end
      end
      CSU_Q2: begin
        next_st.q = CSU_Q3;
        // Operand captured at end of the read quarter (see RULE11)
        if (st.active) begin
          next_st.opnd = i_mem_rdata;
        end
      end
      CSU_Q3: begin
        next_st.q = CSU_Q4;
        // Compare only; no result or flag is written (see RULE4)
        if (st.active) begin
          diff = sub_u(st.opnd, st.working_register);
          if (st.greater) begin
            hit = !diff[8] && (diff[7:0] != 8'h00);       // see RULE2
          end else begin
            hit = diff[8];                                 // see RULE3
          end
          if (hit) begin
            // One or two discarded cycles (see RULE5, RULE6)
            next_st.skips = i_next_two_word ? 2'h2 : 2'h1;
            next_st.taken = 1'b1;
          end
        end
      end
      CSU_Q4: begin
        next_st.q      = CSU_Q1;
        next_st.active = 1'b0;                 // Q4 idle, see RULE11
        // Enter or continue a no-op cycle (see RULE7)
        if (st.skips != CSU_RST_SKIPS) begin
          next_st.nop   = 1'b1;
          next_st.skips = st.skips - 2'h1;
        end else begin
          next_st.nop   = 1'b0;
        end
      end
      default: begin
        next_st = '0;
        next_st.q = CSU_Q1;
      end
    endcase
    // A no-op cycle keeps its full four quarters inert (see RULE7)
    if (st.q == CSU_Q4 && st.skips == CSU_RST_SKIPS) begin
      next_st.nop = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st       <= '0;
      st.q     <= CSU_Q1;
      st.skips <= CSU_RST_SKIPS;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_mem_rd      = st.mem.rd;
  assign o_mem_addr    = st.mem.addr;
  assign o_mem_indexed = st.mem.indexed;
  assign o_quarter     = st.q;
  assign o_busy        = st.active;
  assign o_skip_taken  = st.taken;
  assign o_nop_cycle   = st.nop;

  // Assertions: the quarter sequence is the common time base, so most
  // of them key on o_quarter; internal fields are read only where no
  // port carries the value being judged.

  // Discarded run after a taken skip, one-word successor
  sequence s_nop_one;
    o_nop_cycle[*4] ##1 !o_nop_cycle;
  endsequence : s_nop_one

  // Discarded run after a taken skip, two-word successor
  sequence s_nop_two;
    o_nop_cycle[*8] ##1 !o_nop_cycle;
  endsequence : s_nop_two

  // Decoded compare: read in Q2, busy through Q4, idle again in Q1
  sequence s_compare_run;
    (o_mem_rd && o_busy) ##1 (!o_mem_rd && o_busy) ##1
      (!o_mem_rd && o_busy) ##1 !o_busy;
  endsequence : s_compare_run

  // Quarters are one-hot and run Q1 to Q4 without a gap
  a_quarter_onehot: assert property (@(posedge i_sys_clk) // see RULE11
    disable iff (i_rst) $onehot(o_quarter))
    else $error("quarter not one-hot");

  a_quarter_order: assert property (@(posedge i_sys_clk) // see RULE11
    disable iff (i_rst)
    (o_quarter == CSU_Q1) |=> (o_quarter == CSU_Q2) ##1
      (o_quarter == CSU_Q3) ##1 (o_quarter == CSU_Q4) ##1
      (o_quarter == CSU_Q1))
    else $error("quarter order broken");

  // Read strobe only in Q2 of a decoded compare
  a_read_in_q2: assert property (@(posedge i_sys_clk) // see RULE11
    disable iff (i_rst) o_mem_rd |-> (o_quarter == CSU_Q2) && o_busy)
    else $error("read outside quarter two");

  // After the read the compare stays busy to Q4, then lets go
  a_compare_run: assert property (@(posedge i_sys_clk) // see RULE11
    disable iff (i_rst) o_mem_rd |-> s_compare_run)
    else $error("compare quarters out of step");

  // Address moves only at the decode edge, so it holds between reads
  a_addr_hold: assert property (@(posedge i_sys_clk) // see RULE11
    disable iff (i_rst) (o_quarter != CSU_Q1) |=> $stable(o_mem_addr))
    else $error("address moved outside decode");

  // No-op cycles neither read nor decode nor report a skip
  a_no_decode_nop: assert property (@(posedge i_sys_clk) // see RULE7
    disable iff (i_rst) o_nop_cycle |-> !o_mem_rd && !o_busy)
    else $error("activity in no-op cycle");

  a_nop_no_taken: assert property (@(posedge i_sys_clk) // see RULE7
    disable iff (i_rst) o_nop_cycle |-> !o_skip_taken)
    else $error("skip reported in no-op cycle");

  // Taken skip: one discarded cycle, or two for a two-word successor
  a_taken_one_nop: assert property (@(posedge i_sys_clk) // see RULE5
    disable iff (i_rst)
    o_skip_taken && !$past(i_next_two_word) |-> ##1 s_nop_one)
    else $error("single skip length wrong");

  a_taken_two_nop: assert property (@(posedge i_sys_clk) // see RULE6
    disable iff (i_rst)
    o_skip_taken && $past(i_next_two_word) |-> ##1 s_nop_two)
    else $error("double skip length wrong");

  // Skip flag pulses in Q4 of the compare that raised it
  a_taken_in_q4: assert property (@(posedge i_sys_clk) // see RULE5
    disable iff (i_rst)
    o_skip_taken |-> (o_quarter == CSU_Q4) && $past(o_busy, 2))
    else $error("skip flag at wrong quarter");

  // Unsigned outcome of the greater form, both ways
  a_greater_cmp: assert property (@(posedge i_sys_clk) // see RULE2
    disable iff (i_rst)
    o_busy && st.greater && (o_quarter == CSU_Q3) &&
      (st.opnd > st.working_register) |=> o_skip_taken)
    else $error("greater skip missed");

  a_greater_none: assert property (@(posedge i_sys_clk) // see RULE2
    disable iff (i_rst)
    o_busy && st.greater && (o_quarter == CSU_Q3) &&
      (st.opnd <= st.working_register) |=> !o_skip_taken)
    else $error("greater skip wrongly taken");

  // Unsigned outcome of the less form, both ways
  a_less_hit: assert property (@(posedge i_sys_clk) // see RULE3
    disable iff (i_rst)
    o_busy && !st.greater && (o_quarter == CSU_Q3) &&
      (st.opnd < st.working_register) |=> o_skip_taken)
    else $error("less skip missed");

  a_less_cmp: assert property (@(posedge i_sys_clk) // see RULE3
    disable iff (i_rst)
    o_busy && !st.greater && (o_quarter == CSU_Q3) &&
      (st.opnd >= st.working_register) |=> !o_skip_taken)
    else $error("less skip wrongly taken");

  // Bank bit one: upper address nibble is the bank select register
  a_bank_select: assert property (@(posedge i_sys_clk) // see RULE9
    disable iff (i_rst)
    (o_quarter == CSU_Q1) && (dec_greater || dec_less) && !o_nop_cycle &&
      i_instr[CSU_BANK_BIT] |=>
      o_mem_addr[11:8] == $past(i_bank_select_register))
    else $error("bank select not used");

  // Bank bit zero, not indexed: low half bank 0, high half bank 15
  a_access_bank: assert property (@(posedge i_sys_clk) // see RULE8
    disable iff (i_rst)
    o_mem_rd && !o_mem_indexed && !$past(i_instr[CSU_BANK_BIT]) |->
      (o_mem_addr[11:8] ==
       (o_mem_addr[7] ? CSU_ACCESS_HIGH : CSU_ACCESS_LOW)))
    else $error("quick-access mapping wrong");

  // Indexed mode: greater form, extended set, bank bit zero, low field
  a_indexed_when: assert property (@(posedge i_sys_clk) // see RULE10
    disable iff (i_rst)
    o_mem_rd && st.greater && $past(i_ext_set_en) &&
      !$past(i_instr[CSU_BANK_BIT]) &&
      ($past(i_instr[CSU_ADDR_MSB:0]) <= CSU_INDEX_LIMIT) |->
      o_mem_indexed)
    else $error("indexed mode missed");

  a_indexed_only: assert property (@(posedge i_sys_clk) // see RULE10
    disable iff (i_rst)
    o_mem_indexed && o_mem_rd |-> st.greater && $past(i_ext_set_en) &&
      ($past(i_instr[CSU_ADDR_MSB:0]) <= CSU_INDEX_LIMIT))
    else $error("indexed mode used wrongly");

  // Indexed address is the base plus the literal field, 12-bit wrap
  a_indexed_addr: assert property (@(posedge i_sys_clk) // see RULE10
    disable iff (i_rst)
    o_mem_rd && o_mem_indexed |-> o_mem_addr ==
      $past(i_index_base) + {4'h0, $past(i_instr[CSU_ADDR_MSB:0])})
    else $error("indexed address wrong");

endmodule : csu_compare_skip
`default_nettype wire

//--- verif/csu_mem_model.sv
// Data memory model standing behind the compare-and-skip unit.
// Assumes a read strobe that lasts one quarter and is sampled at its end.
`timescale 1ns/1ps
`default_nettype none
module csu_mem_model (
  // Clock
  input  wire logic        i_sys_clk,
  // Read side from the unit
  input  wire logic        i_rd,
  input  wire logic [11:0] i_addr,
  // Preload side from the bench
  input  wire logic        i_wr,
  input  wire logic [11:0] i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // Operand byte
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:4095]; // Byte store
  logic [7:0] last;         // Last byte driven out
  // Preload, and remember what was last driven
  always_ff @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd) begin
      last <= mem[i_addr];
    end
  end
  // Released bus shows the inverse, so a late sample cannot pass
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
endmodule : csu_mem_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the compare-and-skip unit.
// Assumes one instruction per four clocks, words offered in Q1.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  n_fail++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import csu_pkg::*;
  logic        i_sys_clk, i_rst, i_next_two_word, i_ext_set_en;
  logic [15:0] i_instr;
  logic [7:0]  i_working_register, i_mem_rdata, wr_data;
  logic [3:0]  i_bank_select_register, o_quarter;
  logic [11:0] i_index_base, o_mem_addr, wr_addr;
  logic        o_mem_rd, o_mem_indexed, o_busy, o_skip_taken, o_nop_cycle;
  logic        wr;
  int          n_fail, compares;
  csu_compare_skip i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_instr(i_instr), .i_next_two_word(i_next_two_word),
    .i_working_register(i_working_register),
    .i_bank_select_register(i_bank_select_register),
    .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base),
    .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .o_mem_indexed(o_mem_indexed),
    .o_quarter(o_quarter), .o_busy(o_busy), .o_skip_taken(o_skip_taken),
    .o_nop_cycle(o_nop_cycle));
  csu_mem_model i_mem (.i_sys_clk(i_sys_clk), .i_rd(o_mem_rd),
    .i_addr(o_mem_addr), .i_wr(wr), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_rdata(i_mem_rdata));
  // Free-running 10 MHz clock
  initial i_sys_clk = 1'b0;
  always #50 i_sys_clk = ~i_sys_clk;
  // Step to just after the next rising edge
  task automatic tick;
    @(posedge i_sys_clk);
    #10;
  endtask : tick
  // Report counts and verdict, then stop
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Bounded wait for the first quarter
  task automatic wait_q1;
    int k;
    k = 0;
    while (o_quarter !== 4'h1 && k < 16) begin
      tick();
      k++;
    end
    if (k == 16) begin
      n_fail++;
      $display("Error quarter wait ran out");
      tally_and_finish();
    end
  endtask : wait_q1
  // One compare: preload byte, offer word, follow every quarter
  task automatic run(input logic [15:0] word, input logic [7:0] w,
    input logic [7:0] byt, input logic two, input logic [11:0] ea,
    input logic ei, input logic es);
    int n;
    n = es ? (two ? 8 : 4) : 0;
    wait_q1();
    i_instr = word;
    i_working_register = w;
    wr = 1'b1;
    wr_addr = ea;
    wr_data = byt;
    tick();
    wr = 1'b0;
    i_next_two_word = two;
    `CHK("quarter", 4'h2, o_quarter)
    `CHK("mem_rd", 1'b1, o_mem_rd)
    `CHK("busy", 1'b1, o_busy)
    `CHK("mem_addr", ea, o_mem_addr)
    `CHK("mem_indexed", ei, o_mem_indexed)
    tick();
    tick();
    `CHK("skip_taken", es, o_skip_taken)
    tick();
    for (int k = 0; k < n; k++) begin
      `CHK("nop_cycle", 1'b1, o_nop_cycle)
      `CHK("nop_rd", 1'b0, o_mem_rd)
      tick();
    end
    // Word left up; the next scenario replaces it before its decode edge
    `CHK("nop_end", 1'b0, o_nop_cycle)
  endtask : run
  // Greater form around the unsigned boundary
  task automatic t_greater;
    i_bank_select_register = 4'h3;
    run(16'h6542, 8'h7F, 8'h80, 1'b0, 12'h342, 1'b0, 1'b1);
    run(16'h6542, 8'h80, 8'h80, 1'b0, 12'h342, 1'b0, 1'b0);
    run(16'h6542, 8'hFF, 8'h00, 1'b0, 12'h342, 1'b0, 1'b0);
  endtask : t_greater
  // Less form, two-word successor first
  task automatic t_less;
    run(16'h6142, 8'h80, 8'h7F, 1'b1, 12'h342, 1'b0, 1'b1);
    run(16'h6142, 8'h10, 8'h10, 1'b0, 12'h342, 1'b0, 1'b0);
    run(16'h6142, 8'h00, 8'hFF, 1'b0, 12'h342, 1'b0, 1'b0);
  endtask : t_less
  // Quick-access bank, both halves
  task automatic t_access;
    run(16'h6420, 8'h05, 8'h06, 1'b0, 12'h020, 1'b0, 1'b1);
    run(16'h6090, 8'h06, 8'h05, 1'b1, 12'hF90, 1'b0, 1'b1);
  endtask : t_access
  // Indexed mode at and past its limit, and on the less form
  task automatic t_indexed;
    i_ext_set_en = 1'b1;
    i_index_base = 12'h100;
    run(16'h645F, 8'h01, 8'h02, 1'b0, 12'h15F, 1'b1, 1'b1);
    run(16'h6460, 8'h01, 8'h02, 1'b0, 12'h060, 1'b0, 1'b1);
    run(16'h6010, 8'h01, 8'h02, 1'b0, 12'h010, 1'b0, 1'b0);
    i_ext_set_en = 1'b0;
  endtask : t_indexed
  // Reset in the middle of a two-cycle skip clears the no-op run
  task automatic t_reset_mid;
    wait_q1();
    i_instr = 16'h6542;
    i_working_register = 8'h00;
    wr = 1'b1;
    wr_addr = 12'h342;
    wr_data = 8'h01;
    tick();
    wr = 1'b0;
    i_next_two_word = 1'b1;
    repeat (4) tick();
    `CHK("mid_nop", 1'b1, o_nop_cycle)
    i_rst = 1'b1;
    tick();
    `CHK("rst_quarter", 4'h1, o_quarter)
    `CHK("rst_nop", 1'b0, o_nop_cycle)
    `CHK("rst_busy", 1'b0, o_busy)
    `CHK("rst_taken", 1'b0, o_skip_taken)
    i_rst = 1'b0;
  endtask : t_reset_mid
  // Neighbouring opcodes must leave the unit idle
  task automatic t_refuse;
    wait_q1();
    i_instr = 16'h6242;
    for (int k = 0; k < 8; k++) begin
      tick();
      `CHK("idle_rd", 1'b0, o_mem_rd)
      i_instr = 16'h6742;
    end
    i_instr = 16'h0000;
  endtask : t_refuse
  // Main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    i_rst = 1'b1;
    i_instr = 16'h0000;
    i_next_two_word = 1'b0;
    i_working_register = 8'h00;
    i_bank_select_register = 4'h0;
    i_ext_set_en = 1'b0;
    i_index_base = 12'h000;
    wr = 1'b0;
    wr_addr = 12'h000;
    wr_data = 8'h00;
    repeat (16) tick();
    `CHK("reset_quarter", 4'h1, o_quarter)
    i_rst = 1'b0;
    t_greater();
    t_less();
    t_access();
    t_indexed();
    t_reset_mid();
    t_refuse();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
